// ==== logic/shutter_sequencer.v ====
// shutter sequencer: drives an external shutter around exposures and
// stalls the acquisition sequence for the open/close settle delays
// assumes acquisition logic on sys_clk, presence sense from a pin
`timescale 1ns/1ps
`include "shutter_map.vh"
module shutter_sequencer #(
  parameter TICK_DIV = (`CLK_HZ / 1000) * `TICK_MS
) (
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire [1:0]  shutter_mode,
  input  wire [1:0]  trig_reaction,
  input  wire [10:0] open_delay_ms,
  input  wire [10:0] close_delay_ms,
  input  wire        armed,
  input  wire        expose_req,
  input  wire        expose_done,
  input  wire        sense_pin,
  output wire        expose_go,
  output wire        close_done,
  output reg         shutter_open,
  output wire        seq_busy,
  output wire        mode_valid,
  output wire        int_shutter_present,
  output reg         ext_shutter_present
);
  localparam S_IDLE   = 3'h0;
  localparam S_OPEN   = 3'h1;
  localparam S_EXPOSE = 3'h2;
  localparam S_CLOSE  = 3'h3;
  localparam S_ACK    = 3'h4;
  localparam S_GO     = 3'h5;

  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [10:0] ms_q;
  reg         sense_s1_q;
  reg         sense_s2_q;
  reg         mode_ok;
  reg  [10:0] open_lim;
  reg  [10:0] close_lim;
  wire        tick;
  wire [1:0]  eff_mode;
  wire        open_wait_done;
  wire        close_wait_done;

  ms_tick #(
    .DIV (TICK_DIV)
  ) u_tick (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .tick    (tick)
  );

  // internal shutter never fitted
  assign int_shutter_present = 1'b0;

  // presence sense through three flops
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sense_s1_q          <= 1'b0;
      sense_s2_q          <= 1'b0;
      ext_shutter_present <= 1'b0;
    end else begin
      sense_s1_q          <= sense_pin;
      sense_s2_q          <= sense_s1_q;
      ext_shutter_present <= sense_s2_q;
    end
  end

  // mode availability per trigger reaction
  always @* begin
    case (trig_reaction)
      `TRIG_NONE:       mode_ok = (shutter_mode != `MODE_EARLY_OPEN);
      `TRIG_PER_FRAME:  mode_ok = 1'b1;
      `TRIG_START_ONLY: mode_ok = 1'b1;
      default:          mode_ok = (shutter_mode != `MODE_EARLY_OPEN);
    endcase
  end
  assign mode_valid = mode_ok;
  // unsupported combination falls back to held-closed, the safe state
  assign eff_mode = mode_ok ? shutter_mode : `MODE_HELD_CLOSED;

  // clamp delays to the legal range
  always @* begin
    open_lim  = (open_delay_ms  > `DELAY_MAX_MS) ? `DELAY_MAX_MS : open_delay_ms;
    close_lim = (close_delay_ms > `DELAY_MAX_MS) ? `DELAY_MAX_MS : close_delay_ms;
  end

  // first tick lands anywhere in the ms, so count one extra to never cut the delay short
  assign open_wait_done  = (open_lim == 11'h000) | (ms_q > open_lim);
  assign close_wait_done = (close_lim == 11'h000) | (ms_q > close_lim);

  // sequencer next state
  always @* begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (expose_req) begin
          if (eff_mode == `MODE_GATED)
            state_d = S_OPEN;
          else
            state_d = S_GO;
        end
      end
      S_OPEN: begin
        if (open_wait_done)
          state_d = S_GO;
      end
      S_GO: begin
        state_d = S_EXPOSE;
      end
      S_EXPOSE: begin
        if (expose_done) begin
          if (eff_mode == `MODE_GATED)
            state_d = S_CLOSE;
          else
            state_d = S_ACK;
        end
      end
      S_CLOSE: begin
        if (close_wait_done)
          state_d = S_ACK;
      end
      S_ACK: begin
        state_d = S_IDLE;
      end
      default: state_d = S_IDLE;
    endcase
  end

  // state register and millisecond counter
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      ms_q    <= 11'h000;
    end else begin
      state_q <= state_d;
      if (state_d != state_q)
        ms_q <= 11'h000;
      else if (tick && ms_q != 11'h7FF)
        ms_q <= ms_q + 11'h001;
    end
  end

  // shutter drive by mode
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shutter_open <= 1'b0;
    end else begin
      case (eff_mode)
        `MODE_HELD_CLOSED: shutter_open <= 1'b0;
        `MODE_HELD_OPEN:   shutter_open <= 1'b1;
        `MODE_EARLY_OPEN:  shutter_open <= armed | (state_q != S_IDLE);
        default:           shutter_open <= (state_d == S_OPEN) | (state_d == S_GO) |
                                           (state_d == S_EXPOSE);
      endcase
    end
  end

  // handshakes toward acquisition logic
  assign expose_go  = (state_q == S_GO);
  assign close_done = (state_q == S_ACK);
  assign seq_busy   = (state_q == S_OPEN) | (state_q == S_CLOSE);
endmodule // shutter_sequencer

// ==== logic/shutter_map.vh ====
// constants for the shutter sequencer: modes, trigger reactions, timing
// assumes a 250 MHz system clock and plain ports for configuration
// Contract
// - gated mode opens shutter per exposure, closes once exposure ends
// - held-closed mode keeps shutter closed whatever exposures happen
// - held-open mode keeps shutter open for the whole experiment
// - early-open mode opens shutter as soon as armed for trigger
// - after opening, wait programmable 0..1000 ms in 1 ms steps
// - after closing, wait programmable 0..1000 ms in 1 ms steps
// - internal shutter status always reads absent
// - external shutter presence detected automatically and reported
// - available shutter modes depend on selected trigger reaction
`ifndef SHUTTER_MAP_VH
`define SHUTTER_MAP_VH
// shutter modes
`define MODE_GATED       2'h0
`define MODE_HELD_CLOSED 2'h1
`define MODE_HELD_OPEN   2'h2
`define MODE_EARLY_OPEN  2'h3
// trigger reactions
`define TRIG_NONE        2'h0
`define TRIG_PER_FRAME   2'h1
`define TRIG_START_ONLY  2'h2
`define TRIG_FAST_FRAME  2'h3
// timing
`define CLK_HZ           250000000
`define TICK_MS          1
`define DELAY_MAX_MS     11'h3E8
`define DELAY_W          11
`endif

// ==== logic/ms_tick.v ====
// one-millisecond enable pulse divided down from the system clock
// assumes a single free-running clock; period is a parameter
`timescale 1ns/1ps
module ms_tick #(
  parameter DIV = 250000
) (
  input  wire sys_clk,
  input  wire rst_n,
  output reg  tick
);
  reg [17:0] cnt_q;

  // divider: one pulse every DIV cycles
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 18'h00000;
      tick  <= 1'b0;
    end else if (cnt_q == DIV[17:0] - 18'h00001) begin
      cnt_q <= 18'h00000;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 18'h00001;
      tick  <= 1'b0;
    end
  end
endmodule // ms_tick

// ==== verif/shutter_sequencer_assertions.sv ====
// port checker for the shutter sequencer
// assumes it is bound onto shutter_sequencer
`timescale 1ns/1ps
module shutter_sequencer_assertions (
  input wire       sys_clk,
  input wire       rst_n,
  input wire [1:0] shutter_mode,
  input wire [1:0] trig_reaction,
  input wire       armed,
  input wire       sense_pin,
  input wire       expose_go,
  input wire       close_done,
  input wire       shutter_open,
  input wire       mode_valid,
  input wire       int_shutter_present,
  input wire       ext_shutter_present
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // shutter level, presence and mode validity against mode, sequence and sense
  chk_int_absent: assert property (!int_shutter_present) else $error("int shown");
  chk_held_closed: assert property ((shutter_mode == 2'h1)[*2] |=> !shutter_open) else $error("opened");
  chk_held_open: assert property ((mode_valid && shutter_mode == 2'h2)[*2] |=> shutter_open) else $error("shut");
  chk_early_open: assert property ((mode_valid && armed && shutter_mode == 2'h3)[*2] |=> shutter_open)
    else $error("not early");
  chk_gated_go: assert property (shutter_mode == 2'h0 && expose_go |-> shutter_open) else $error("go shut");
  chk_gated_end: assert property (shutter_mode == 2'h0 && close_done |-> !shutter_open) else $error("end open");
  chk_ext_sense: assert property ($stable(sense_pin)[*4] |-> ext_shutter_present == sense_pin) else $error("sense");
  chk_mode_gate: assert property (trig_reaction == 2'h0 && shutter_mode == 2'h3 |-> !mode_valid) else $error("mode");
endmodule // shutter_sequencer_assertions
bind shutter_sequencer shutter_sequencer_assertions i_chk (.*);

// ==== verif/shutter_model.sv ====
// external shutter: presence sense line only
// assumes a pull-down on the sense line when unplugged
`timescale 1ns/1ps
module shutter_model (
  input  wire attached,
  output wire sense_pin
);
  // low when nothing is plugged in
  assign sense_pin = attached;
endmodule // shutter_model

// ==== verif/shutter_sequencer_tb.sv ====
// bench for the shutter sequencer, tick shortened to 10 cycles
// assumes the shutter model and bound checker
`timescale 1ns/1ps
module shutter_sequencer_tb;
  reg        sys_clk, rst_n, armed, expose_req, expose_done, attached, was_open, saw_busy;
  reg [1:0]  shutter_mode, trig_reaction;
  reg [10:0] open_delay_ms, close_delay_ms;
  wire       sense_pin, expose_go, close_done, shutter_open, seq_busy, mode_valid, int_shutter_present;
  wire       ext_shutter_present;
  integer    error_cnt, compares, n_go, n_cl;
  shutter_sequencer #(.TICK_DIV(10)) i_dut (.*);
  shutter_model i_shut (.attached(attached), .sense_pin(sense_pin));
  task check(input seen, input exp); begin
    compares = compares + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  end endtask
  task conclude; begin
    if (error_cnt == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  end endtask
  // one full request, counting both waits
  task seq(input [1:0] m, input [10:0] od, input [10:0] cd); begin
    @(posedge sys_clk); shutter_mode <= m; open_delay_ms <= od; close_delay_ms <= cd; expose_req <= 1'b1;
    saw_busy = 1'b0;
    @(posedge sys_clk); expose_req <= 1'b0;
    @(negedge sys_clk);
    for (n_go = 0; expose_go !== 1'b1 && n_go < 12000; n_go = n_go + 1) begin
      saw_busy = saw_busy | (seq_busy === 1'b1);
      @(negedge sys_clk);
    end
    was_open = shutter_open;
    @(posedge sys_clk); expose_done <= 1'b1;
    @(posedge sys_clk); expose_done <= 1'b0;
    @(negedge sys_clk);
    for (n_cl = 0; close_done !== 1'b1 && n_cl < 12000; n_cl = n_cl + 1) @(negedge sys_clk);
  end endtask
  // gated timing at both ends of the range, clamp included
  task t_gated; begin
    seq(2'h0, 11'h003, 11'h000);
    check(was_open, 1'b1);
    check(saw_busy, 1'b1);
    check(n_go >= 30 && n_go <= 44, 1'b1);
    check(n_cl <= 3, 1'b1);
    check(shutter_open, 1'b0);
    seq(2'h0, 11'h000, 11'h7FF);
    check(n_go <= 3, 1'b1);
    check(n_cl >= 10000 && n_cl <= 10014, 1'b1);
  end endtask
  // held modes ignore the exposure
  task t_held; begin
    seq(2'h1, 11'h000, 11'h000);
    check(was_open, 1'b0);
    check(saw_busy, 1'b0);
    seq(2'h2, 11'h000, 11'h000);
    check(was_open & shutter_open, 1'b1);
  end endtask
  // early open on armed, refused with no trigger
  task t_early; begin
    @(posedge sys_clk); shutter_mode <= 2'h3; armed <= 1'b1;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk); check(shutter_open & mode_valid, 1'b1);
    @(posedge sys_clk); trig_reaction <= 2'h0;
    @(negedge sys_clk); check(mode_valid, 1'b0);
    @(posedge sys_clk); trig_reaction <= 2'h2;
    @(negedge sys_clk); check(mode_valid, 1'b1);
    @(posedge sys_clk); trig_reaction <= 2'h3; armed <= 1'b0;
    @(negedge sys_clk); check(mode_valid, 1'b0);
    @(posedge sys_clk); trig_reaction <= 2'h1; // early-open also refused with fast-frame, back to per-frame
  end endtask
  // presence follows the sense line
  task t_status; begin
    check(int_shutter_present, 1'b0);
    @(posedge sys_clk); attached <= 1'b1;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk); check(ext_shutter_present, 1'b1);
  end endtask
  initial begin sys_clk = 1'b0; forever #2 sys_clk = ~sys_clk; end
  initial begin #200000; error_cnt = error_cnt + 1; conclude; end
  initial begin
    rst_n = 1'b0; armed = 1'b0; expose_req = 1'b0; expose_done = 1'b0; attached = 1'b0;
    shutter_mode = 2'h1; trig_reaction = 2'h1; open_delay_ms = 11'h000; close_delay_ms = 11'h000;
    error_cnt = 0; compares = 0;
    repeat (4) @(posedge sys_clk); rst_n <= 1'b1;
    t_status; t_gated; t_held; t_early;
    conclude;
  end
endmodule // shutter_sequencer_tb
